// File: hdl/cmsef_pkg.sv
package cmsef_pkg;

    // Message objects and their index width.
    localparam int unsigned NOBJ = 14;
    localparam int unsigned OBJW = 4;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [9:0] IDX_TEC  = 10'h09c;
    localparam logic [9:0] IDX_REC  = 10'h09d;
    localparam logic [9:0] IDX_STAT = 10'h0b2;
    localparam logic [9:0] IDX_PAGE = 10'h0b1;
    localparam logic [9:0] IDX_OCTL = 10'h0b3;
    localparam logic [9:0] IDX_CFG  = 10'h0ab;

    // Configuration bit positions.
    localparam int unsigned CFG_AUTOBAUD = 0;
    localparam int unsigned CFG_EN_TX    = 1;
    localparam int unsigned CFG_EN_RX    = 2;
    localparam int unsigned CFG_EN_ERR   = 3;

    // Object status bit positions.
    localparam int unsigned ST_LENGTH_MISMATCH_WARNING  = 7;
    localparam int unsigned ST_TXD   = 6;
    localparam int unsigned ST_RXD   = 5;
    localparam int unsigned ST_BIT   = 4;
    localparam int unsigned ST_STUFF = 3;
    localparam int unsigned ST_CRC   = 2;
    localparam int unsigned ST_FORM  = 1;
    localparam int unsigned ST_ACK   = 0;

    // Reset values and counter steps.
    localparam logic [7:0] TEC_RST    = 8'h00;
    localparam logic [7:0] REC_RST    = 8'h00;
    localparam logic [3:0] CFG_RST    = 4'h0;
    localparam logic [7:0] TX_ERR_INC = 8'h08;
    localparam logic [7:0] RX_ERR_INC = 8'h01;
    localparam logic [7:0] OK_DEC     = 8'h01;
    localparam logic [7:0] CNT_MAX    = 8'hff;

    // Frame checking constants.
    localparam logic [2:0]  STUFF_LIMIT = 3'h5;
    localparam logic [14:0] CRC_POLY    = 15'h4599;

    // Field that the bit currently sampled belongs to.
    typedef enum logic [3:0] {
        FLD_IDLE    = 4'h0,
        FLD_SOF     = 4'h1,
        FLD_ARB     = 4'h2,
        FLD_CTRL    = 4'h3,
        FLD_DATA    = 4'h4,
        FLD_CRC     = 4'h5,
        FLD_CRC_DEL = 4'h6,
        FLD_ACK     = 4'h7,
        FLD_ACK_DEL = 4'h8,
        FLD_EOF     = 4'h9,
        FLD_ERRFRM  = 4'ha
    } cmsef_field_e;

    // One bit as seen at the sample point.
    typedef struct packed {
        logic         smp;
        logic         rx;
        logic         tx;
        logic         xmit;
        cmsef_field_e fld;
    } cmsef_bit_s;

    // Error pulses, with the role the node had when they arose.
    typedef struct packed {
        logic tx;
        logic bit_err;
        logic stuff_err;
        logic crc_err;
        logic form_err;
        logic ack_err;
    } cmsef_err_s;

endpackage

// File: hdl/cmsef_bit_check.sv
`timescale 1ns/1ps
module cmsef_bit_check
    import cmsef_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire cmsef_bit_s link,
    output cmsef_err_s      err
);

    typedef struct packed {
        logic       last;
        logic [2:0] run;
        logic [14:0] crc;
        logic [14:0] rcrc;
        cmsef_err_s err;
    } cmsef_chk_s;

    cmsef_chk_s q;
    cmsef_chk_s d;
    logic       stuffed;
    logic       isdata;
    logic       nxt;
    logic [14:0] base;

    // Destuffing, CRC and field checks, evaluated once per sample point.
    always_comb begin
        d       = q;
        d.err   = '0;
        isdata  = 1'b0;
        nxt     = 1'b0;
        base    = (link.fld == FLD_SOF) ? 15'h0000 : q.crc;
        stuffed = link.fld inside {FLD_SOF, FLD_ARB, FLD_CTRL, FLD_DATA, FLD_CRC};
        if (link.smp) begin
            d.err.tx = link.xmit;
            if (!stuffed) begin
                d.run = 3'h0;
            end else if (q.run == STUFF_LIMIT) begin
                // A sixth equal level where a stuff bit belongs.
                d.err.stuff_err = (link.rx == q.last);
                d.run           = 3'h1;
                d.last          = link.rx;
            end else begin
                isdata = 1'b1;
                d.run  = (q.run != 3'h0 && link.rx == q.last) ? q.run + 3'h1 : 3'h1;
                d.last = link.rx;
            end
            // CRC over destuffed bits from start of frame through data.
            if (isdata && link.fld inside {FLD_SOF, FLD_ARB, FLD_CTRL, FLD_DATA}) begin
                nxt   = link.rx ^ base[14];
                d.crc = {base[13:0], 1'b0} ^ (nxt ? CRC_POLY : 15'h0000);
            end
            if (isdata && link.fld == FLD_CRC) begin
                d.rcrc = {q.rcrc[13:0], link.rx};
            end
            // Compare only as a receiver, at the CRC delimiter.
            d.err.crc_err  = link.fld == FLD_CRC_DEL && !link.xmit && q.rcrc != q.crc;
            // Fixed recessive fields must not be dominant.
            d.err.form_err = link.fld inside {FLD_CRC_DEL, FLD_ACK_DEL, FLD_EOF} && !link.rx;
            // Recessive read back where a dominant would be expected.
            d.err.ack_err  = link.xmit && link.fld == FLD_ACK && link.rx;
            // Mismatch while sending, minus the overwrite-allowed cases.
            d.err.bit_err  = link.xmit && link.rx != link.tx &&
                             !(link.tx && link.fld inside {FLD_ARB, FLD_ACK, FLD_ERRFRM});
        end
    end

    // The checker state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign err = q.err;

    a_ack_err_set: assert property (@(posedge pclk) disable iff (!presetn)
        link.smp && link.xmit && link.fld == FLD_ACK && link.rx |=> err.ack_err)
        else $error("ack error not flagged");
    a_arb_exempt: assert property (@(posedge pclk) disable iff (!presetn)
        link.smp && link.fld == FLD_ARB && link.tx && !link.rx |=> !err.bit_err)
        else $error("bit error raised in arbitration");
    a_form_eof: assert property (@(posedge pclk) disable iff (!presetn)
        link.smp && link.fld == FLD_EOF && !link.rx |=> err.form_err)
        else $error("form error missed in end of frame");
    a_stuff_run: assert property (@(posedge pclk) disable iff (!presetn)
        err.stuff_err |-> $past(q.run) == STUFF_LIMIT)
        else $error("stuff error without five equal bits");
    a_crc_rx_only: assert property (@(posedge pclk) disable iff (!presetn)
        err.crc_err |-> !err.tx)
        else $error("crc error raised while sending");
    c_stuff_err: cover property (@(posedge pclk) err.stuff_err);

endmodule

// File: hdl/cmsef_top.sv
`timescale 1ns/1ps
// Behaviour
// - Transmit error counter, 8 bits, read only, zero after reset.
// - Receive error counter, 8 bits, read only, zero after reset.
// - Set length mismatch warning when received length differs from configured one.
// - Every reception overwrites the object's configured length with the received one.
// - Set transmit done when the object's transmission completes.
// - Lowest enabled object index is sent next.
// - Set receive done when the object's reception completes.
// - On multiple matches the lowest index object is updated.
// - While sending, a read-back level differing from the driven one is a bit error.
// - No bit error for overwritten recessive in arbitration, ack slot or error frame.
// - More than five equal bits in a stuffed field is a stuff error.
// - Receiver checks CRC over destuffed bits against the received CRC field.
// - Dominant in CRC delimiter, ack delimiter or end of frame is a form error.
// - Flags stay set until software clears them; each can request an interrupt.
// - Object status has no reset value; software must initialise it.
// - Listen-only mode freezes both error counters.
// - Listen-only mode neither acknowledges nor transmits but still flags errors.
module cmsef_top
    import cmsef_pkg::*;
#(
    parameter int unsigned N_OBJ = NOBJ
)(
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire cmsef_bit_s       link,
    input  wire logic [N_OBJ-1:0] tx_enabled,
    input  wire logic             tx_done,
    input  wire logic             rx_done,
    input  wire logic [N_OBJ-1:0] rx_hit,
    input  wire logic [3:0]       rx_dlc,
    input  wire logic [OBJW-1:0]  rx_cur_obj,
    output logic      [OBJW-1:0]  tx_obj_idx,
    output logic                  tx_obj_valid,
    output logic                  listen_only,
    output logic                  irq_req
);

    typedef struct packed {
        logic [7:0]                  tec;
        logic [7:0]                  rec;
        logic [3:0]                  cfg;
        logic [OBJW-1:0]             page;
        logic [N_OBJ-1:0][3:0]       dlc;
        logic [N_OBJ-1:0][7:0]       stat;
        logic [31:0]                 prdata;
        logic                        pready;
        logic                        pslverr;
        logic [OBJW-1:0]             txi;
        logic                        txv;
        logic                        irq;
    } cmsef_state_s;

    cmsef_state_s q;
    cmsef_state_s d;
    cmsef_err_s   err;
    logic [9:0]   idx;
    logic         wr;
    logic         pg_ok;
    logic         any_err;
    logic [OBJW:0] txsel;
    logic [OBJW:0] rxsel;
    logic [OBJW-1:0] eobj;
    logic [N_OBJ-1:0][7:0] set;
    logic [7:0]   wmask;

    // Lowest set bit of a request vector, with a found flag on top.
    function automatic logic [OBJW:0] lowest(input logic [N_OBJ-1:0] v);
        logic [OBJW:0] r;
        r = '0;
        for (int i = N_OBJ - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = {1'b1, OBJW'(i)};
            end
        end
        return r;
    endfunction

    // Bit-level frame checks feed the error flags and the counters.
    cmsef_bit_check u_chk (
        .pclk    (pclk),
        .presetn (presetn),
        .link    (link),
        .err     (err)
    );

    // Bus decode; the register is read in the setup cycle and answered next.
    always_comb begin
        idx   = paddr[11:2];
        pg_ok = 32'(q.page) < N_OBJ;
        wr    = psel && penable && q.pready && pwrite;
        wmask = (wr && idx == IDX_STAT && pg_ok) ? pwdata[7:0] : 8'hff;
    end

    // Event routing: which object each hardware event marks.
    always_comb begin
        set     = '0;
        txsel   = lowest(tx_enabled);
        rxsel   = lowest(rx_hit);
        eobj    = err.tx ? q.txi : rx_cur_obj;
        any_err = err.bit_err | err.stuff_err | err.crc_err | err.form_err | err.ack_err;
        if (tx_done && q.txv) begin
            set[q.txi][ST_TXD] = 1'b1;
        end
        if (rx_done && rxsel[OBJW]) begin
            set[rxsel[OBJW-1:0]][ST_RXD]  = 1'b1;
            set[rxsel[OBJW-1:0]][ST_LENGTH_MISMATCH_WARNING] = rx_dlc != q.dlc[rxsel[OBJW-1:0]];
        end
        // Flags are raised in listen-only mode too, for baud search.
        if (32'(eobj) < N_OBJ) begin
            set[eobj][ST_BIT]   = err.bit_err;
            set[eobj][ST_STUFF] = err.stuff_err;
            set[eobj][ST_CRC]   = err.crc_err;
            set[eobj][ST_FORM]  = err.form_err;
            set[eobj][ST_ACK]   = err.ack_err;
        end
    end

    // Next state of the whole block.
    always_comb begin
        d         = q;
        d.pready  = psel && !penable;
        d.pslverr = 1'b0;
        d.prdata  = '0;
        if (psel && !penable) begin
            unique case (idx)
                IDX_TEC:  d.prdata[7:0] = q.tec;
                IDX_REC:  d.prdata[7:0] = q.rec;
                IDX_STAT: d.prdata[7:0] = pg_ok ? q.stat[q.page] : 8'h00;
                IDX_PAGE: d.prdata[OBJW-1:0] = q.page;
                IDX_OCTL: d.prdata[3:0] = pg_ok ? q.dlc[q.page] : 4'h0;
                IDX_CFG:  d.prdata[3:0] = q.cfg;
                default:  d.pslverr = 1'b1;
            endcase
        end
        // Counters have no write path, so a bus write cannot disturb them.
        if (wr && idx == IDX_CFG) begin
            d.cfg = pwdata[3:0];
        end
        if (wr && idx == IDX_PAGE) begin
            d.page = pwdata[OBJW-1:0];
        end
        if (wr && idx == IDX_OCTL && pg_ok) begin
            d.dlc[q.page] = pwdata[3:0];
        end
        // Reception wins over a software length write in the same cycle.
        if (rx_done && rxsel[OBJW]) begin
            d.dlc[rxsel[OBJW-1:0]] = rx_dlc;
        end
        // Sticky flags: software clears by writing zero, a set in that cycle wins.
        for (int i = 0; i < N_OBJ; i++) begin
            if (OBJW'(i) == q.page) begin
                d.stat[i] = (q.stat[i] & wmask) | set[i];
            end else begin
                d.stat[i] = q.stat[i] | set[i];
            end
        end
        // Simplified confinement: saturating at the counter width, no bus-off state.
        if (!q.cfg[CFG_AUTOBAUD]) begin
            if (any_err && err.tx) begin
                d.tec = (q.tec > CNT_MAX - TX_ERR_INC) ? CNT_MAX : q.tec + TX_ERR_INC;
            end else if (tx_done && q.txv && q.tec != 8'h00) begin
                d.tec = q.tec - OK_DEC;
            end
            if (any_err && !err.tx) begin
                d.rec = (q.rec == CNT_MAX) ? CNT_MAX : q.rec + RX_ERR_INC;
            end else if (rx_done && rxsel[OBJW] && q.rec != 8'h00) begin
                d.rec = q.rec - OK_DEC;
            end
        end
        // No object is offered for sending while only listening.
        d.txi = txsel[OBJW-1:0];
        d.txv = txsel[OBJW] && !q.cfg[CFG_AUTOBAUD];
        // Interrupt request from any enabled flag of any object.
        d.irq = 1'b0;
        for (int i = 0; i < N_OBJ; i++) begin
            d.irq = d.irq | (q.cfg[CFG_EN_TX] & q.stat[i][ST_TXD])
                          | (q.cfg[CFG_EN_RX] & q.stat[i][ST_RXD])
                          | (q.cfg[CFG_EN_ERR] & (|{q.stat[i][ST_LENGTH_MISMATCH_WARNING], q.stat[i][4:0]}));
        end
    end

    // Status flags are left out of the reset so they come up undefined.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.tec     <= TEC_RST;
            q.rec     <= REC_RST;
            q.cfg     <= CFG_RST;
            q.page    <= '0;
            q.dlc     <= '0;
            q.prdata  <= '0;
            q.pready  <= 1'b0;
            q.pslverr <= 1'b0;
            q.txi     <= '0;
            q.txv     <= 1'b0;
            q.irq     <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // Every output is a flip-flop of the state.
    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign tx_obj_idx   = q.txi;
    assign tx_obj_valid = q.txv;
    assign listen_only  = q.cfg[CFG_AUTOBAUD];
    assign irq_req      = q.irq;

    a_counters_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        q.cfg[CFG_AUTOBAUD] |=> $stable(q.tec) && $stable(q.rec))
        else $error("error counter moved in listen-only mode");
    a_tec_step: assert property (@(posedge pclk) disable iff (!presetn)
        !q.cfg[CFG_AUTOBAUD] && err.tx && err.ack_err && q.tec < 8'hf0 |=> q.tec == $past(q.tec) + TX_ERR_INC)
        else $error("transmit error counter did not rise by eight");
    a_tx_lowest: assert property (@(posedge pclk) disable iff (!presetn)
        !q.cfg[CFG_AUTOBAUD] && tx_enabled[0] |=> q.txi == '0 && q.txv)
        else $error("object zero not chosen first");
    a_no_tx_listen: assert property (@(posedge pclk) disable iff (!presetn)
        q.cfg[CFG_AUTOBAUD] |=> !q.txv)
        else $error("object offered while only listening");
    a_txdone_set: assert property (@(posedge pclk) disable iff (!presetn)
        tx_done && q.txv |=> q.stat[$past(q.txi)][ST_TXD])
        else $error("transmit done flag not set");
    a_dlc_update: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && rxsel[OBJW] |=> q.dlc[$past(rxsel[OBJW-1:0])] == $past(rx_dlc))
        else $error("received length not stored");
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done && rxsel[OBJW] && wr && idx == IDX_STAT |=> q.stat[$past(rxsel[OBJW-1:0])][ST_RXD])
        else $error("clear beat a hardware set");
    a_pready_next: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready ##1 !pready)
        else $error("bus answer not one cycle after setup");
    c_tx_done: cover property (@(posedge pclk) disable iff (!presetn) tx_done && q.txv);
    c_dlc_warn: cover property (@(posedge pclk) disable iff (!presetn) |set[0][ST_LENGTH_MISMATCH_WARNING]);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq_req));

endmodule

// File: verif/cmsef_can_node.sv
`timescale 1ns/1ps
// Stands in for the other nodes on the bus and the bit timing logic: one sampled bit per pulse.
module cmsef_can_node
    import cmsef_pkg::*;
(
    input  wire logic pclk,
    output cmsef_bit_s link
);
    // Bus is idle and no sample pulse is pending at start.
    initial begin
        link = '{smp: 1'b0, rx: 1'b1, tx: 1'b1, xmit: 1'b0, fld: FLD_IDLE};
    end

    // The gap argument stretches the bit time so slow bit rates are exercised too.
    // Between pulses the level is shown inverted, so nothing may rely on a stale sample.
    task automatic put_bit(input logic rx, input logic tx, input logic xmit,
                           input cmsef_field_e fld, input int gap);
        @(posedge pclk);
        link <= '{smp: 1'b1, rx: rx, tx: tx, xmit: xmit, fld: fld};
        @(posedge pclk);
        link.smp <= 1'b0;
        link.rx  <= ~rx;
        repeat (gap) @(posedge pclk);
    endtask
endmodule

// File: verif/can_msg_status_error_flags_tb.sv
`timescale 1ns/1ps
module can_msg_status_error_flags_tb
    import cmsef_pkg::*;
();
    logic            pclk;
    logic            presetn;
    logic            psel;
    logic            penable;
    logic            pwrite;
    logic [11:0]     paddr;
    logic [31:0]     pwdata;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    cmsef_bit_s      link;
    logic [NOBJ-1:0] tx_enabled;
    logic            tx_done;
    logic            rx_done;
    logic [NOBJ-1:0] rx_hit;
    logic [3:0]      rx_dlc;
    logic [OBJW-1:0] rx_cur_obj;
    logic [OBJW-1:0] tx_obj_idx;
    logic            tx_obj_valid;
    logic            listen_only;
    logic            irq_req;
    logic [31:0]     rd;
    logic            err;
    int              failures;
    int              num_checks;
    cmsef_field_e    fl[3] = '{FLD_CRC_DEL, FLD_ACK_DEL, FLD_EOF};

    cmsef_top #(.N_OBJ(NOBJ)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link), .tx_enabled(tx_enabled), .tx_done(tx_done), .rx_done(rx_done),
        .rx_hit(rx_hit), .rx_dlc(rx_dlc), .rx_cur_obj(rx_cur_obj), .tx_obj_idx(tx_obj_idx),
        .tx_obj_valid(tx_obj_valid), .listen_only(listen_only), .irq_req(irq_req));
    cmsef_can_node node (.pclk(pclk), .link(link));

    // Clock of 8 ns period.
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high, then released.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Data and response are taken at the very edge that samples pready high; only the watchdog ends a hang.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        check(nm, rd, exp);
    endtask

    // Status is banked per object, so the page is selected first.
    task automatic chk_st(input logic [3:0] obj, input logic [7:0] exp);
        apb(1'b1, IDX_PAGE, {28'h0, obj});
        chk("status", IDX_STAT, {24'h0, exp});
    endtask

    task automatic settle;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic pulse_tx;
        @(posedge pclk);
        tx_done <= 1'b1;
        @(posedge pclk);
        tx_done <= 1'b0;
    endtask

    task automatic pulse_rx(input logic [NOBJ-1:0] hit, input logic [3:0] dlc);
        @(posedge pclk);
        rx_hit  <= hit;
        rx_dlc  <= dlc;
        rx_done <= 1'b1;
        @(posedge pclk);
        rx_done <= 1'b0;
    endtask

    // A frame always starts from idle so that stuff and CRC tracking restart.
    task automatic frame(input logic xmit);
        node.put_bit(1'b1, 1'b1, xmit, FLD_IDLE, 0);
        node.put_bit(1'b0, !xmit, xmit, FLD_SOF, 0);
    endtask

    task automatic zeros(input int n);
        for (int i = 0; i < n; i++) begin
            node.put_bit(1'b0, 1'b1, 1'b0, FLD_DATA, 0);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog; the whole sequence needs well under a tenth of this span.
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        tally_and_finish();
    end

    // Main sequence.
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, tx_done, rx_done} = '0;
        {paddr, pwdata, tx_enabled, rx_hit, rx_dlc, rx_cur_obj} = '0;
        failures = 0;
        num_checks = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        chk("tec reset", IDX_TEC, 32'h0);
        chk("rec reset", IDX_REC, 32'h0);
        apb(1'b1, IDX_TEC, 32'h55);
        apb(1'b1, IDX_REC, 32'h55);
        chk("tec ro", IDX_TEC, 32'h0);
        chk("rec ro", IDX_REC, 32'h0);
        apb(1'b0, 10'h000, 32'h0);
        check("unmapped", {31'h0, err}, 32'h1);
        // Status comes up undefined, so every object is cleared before use.
        for (int i = 0; i < NOBJ; i++) begin
            apb(1'b1, IDX_PAGE, 32'(i));
            apb(1'b1, IDX_STAT, 32'h0);
        end
        apb(1'b1, IDX_CFG, 32'h0000000e);
        tx_enabled <= 14'h2028;
        settle();
        check("tx idx", {28'h0, tx_obj_idx}, 32'h3);
        check("tx valid", {31'h0, tx_obj_valid}, 32'h1);
        pulse_tx();
        chk_st(4'h3, 8'h40);
        check("irq set", {31'h0, irq_req}, 32'h1);
        apb(1'b1, IDX_STAT, 32'hff);
        chk_st(4'h3, 8'h40);
        apb(1'b1, IDX_STAT, 32'h0);
        settle();
        check("irq clear", {31'h0, irq_req}, 32'h0);
        // Transmitter reads back recessive in the ack slot, then succeeds.
        frame(1'b1);
        node.put_bit(1'b1, 1'b1, 1'b1, FLD_ACK, 0);
        chk_st(4'h3, 8'h01);
        chk("tec ack", IDX_TEC, 32'h8);
        pulse_tx();
        chk("tec ok", IDX_TEC, 32'h7);
        apb(1'b1, IDX_STAT, 32'h0);
        // Losing arbitration is legal; an overwritten data bit is not.
        frame(1'b1);
        node.put_bit(1'b0, 1'b1, 1'b1, FLD_ARB, 3);
        chk_st(4'h3, 8'h00);
        node.put_bit(1'b0, 1'b1, 1'b1, FLD_DATA, 0);
        chk_st(4'h3, 8'h10);
        chk("tec bit", IDX_TEC, 32'hf);
        // Five equal bits pass, the sixth is a stuff error charged to the receive object.
        rx_cur_obj <= 4'h5;
        frame(1'b0);
        zeros(4);
        chk_st(4'h5, 8'h00);
        zeros(1);
        chk_st(4'h5, 8'h08);
        chk("rec stuff", IDX_REC, 32'h1);
        // CRC over a lone dominant start bit is zero; a non-zero field must be refused.
        rx_cur_obj <= 4'h6;
        frame(1'b0);
        for (int i = 0; i < 15; i++) begin
            node.put_bit(!i[0], 1'b1, 1'b0, FLD_CRC, 0);
        end
        node.put_bit(1'b1, 1'b1, 1'b0, FLD_CRC_DEL, 0);
        chk_st(4'h6, 8'h04);
        chk("rec crc", IDX_REC, 32'h2);
        // Listen-only mode still flags errors but leaves the counters alone.
        apb(1'b1, IDX_CFG, 32'h0000000f);
        settle();
        check("listen", {31'h0, listen_only}, 32'h1);
        check("no send", {31'h0, tx_obj_valid}, 32'h0);
        rx_cur_obj <= 4'h7;
        frame(1'b0);
        zeros(5);
        chk_st(4'h7, 8'h08);
        chk("rec frozen", IDX_REC, 32'h2);
        chk("tec frozen", IDX_TEC, 32'hf);
        apb(1'b1, IDX_CFG, 32'h0000000e);
        // A dominant level in each fixed-form field.
        for (int i = 0; i < 3; i++) begin
            rx_cur_obj <= 4'(8 + i);
            frame(1'b0);
            node.put_bit(1'b0, 1'b1, 1'b0, fl[i], 0);
            apb(1'b1, IDX_PAGE, 32'(8 + i));
            apb(1'b0, IDX_STAT, 32'h0);
            check("form flag", {31'h0, rd[ST_FORM]}, 32'h1);
        end
        // Two objects hit with a longer length than configured; only the lower one takes it.
        // Object eleven has seen no error so far, so any flag on it comes from this frame.
        apb(1'b1, IDX_PAGE, 32'h4);
        apb(1'b1, IDX_OCTL, 32'h3);
        pulse_rx(14'h0810, 4'h8);
        chk_st(4'h4, 8'ha0);
        chk("length", IDX_OCTL, 32'h8);
        chk_st(4'hb, 8'h00);
        apb(1'b1, IDX_PAGE, 32'h4);
        apb(1'b1, IDX_STAT, 32'h0);
        pulse_rx(14'h0010, 4'h8);
        chk_st(4'h4, 8'h20);
        // A clear lands in the same cycle as a receive set on the paged object; the set must survive.
        fork
            apb(1'b1, IDX_STAT, 32'h0);
            begin
                @(posedge pclk);
                pulse_rx(14'h0010, 4'h8);
            end
        join
        chk_st(4'h4, 8'h20);
        tally_and_finish();
    end
endmodule
